// ==== core/tcb_top.v ====
// Trace capture buffer: acquisition control, AXI4-Lite registers and readout buffer
// Behaviour
// RULE1: The store holds a programmable number of samples per probe, from zero up to 128K entries.
// RULE2: Software selects either one undivided buffer or a buffer cut into segments.
// RULE3: Undivided, the whole memory is one FIFO written every sample until the trigger arrives.
// RULE4: Before the trigger a full buffer overwrites its oldest sample, wrapping circularly.
// RULE5: After the trigger sampling goes on until the buffer is full, the count set by trigger position.
// RULE6: Post, centre and pre positions keep mostly pre-trigger, half, or mostly post-trigger data.
// RULE7: A custom post-trigger count may be programmed instead of the fixed positions.
// RULE8: Segmented, the memory splits into a selectable number of equal segments, each with its own trigger.
// RULE9: Each segment behaves as an undivided circular buffer with the same trigger position handling.
// RULE10: Only the active segment is written at any time.
// RULE11: When the active segment's trigger is met and it fills, capture moves to the next segment.
// RULE12: Per-segment trigger conditions come from the trigger input vector only in custom flow, else bit 0.
// RULE13: Sample qualification is honoured only in undivided mode.
// RULE14: The capture memory is a dedicated instance shared with no user logic.
// RULE15: With qualification on, the qualifier is the per-cycle write enable.
// RULE16: Segment depth is total depth divided by segment count and addressing wraps inside the segment.
`timescale 1ns/1ps
`include "tcb_regs.vh"
module tcb_top #(
  parameter WIDTH    = 32,
  parameter AW       = 17,
  parameter MAX_SEGS = 16
) (
  // Clock, reset, enable
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             ce,
  // Probed user signals
  input  wire [WIDTH-1:0] probe,
  input  wire             qual,
  input  wire [MAX_SEGS-1:0] trig,
  // AXI4-Lite write channels
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  output reg  [1:0]       s_axi_bresp,
  // AXI4-Lite read channels
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  input  wire [7:0]       s_axi_araddr,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp
);
  // ****************************************
  // State encodings
  // ****************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PRE  = 3'b010;
  localparam [2:0] ST_POST = 3'b100;
  localparam [AW:0] MAX_DEPTH = 18'h2_0000;
  localparam [AW-1:0] ONE = 1;
  // Registers
  reg [31:0]   ctrl_q, cfg_q;
  reg [AW:0]   depth_q, tpos_q, post_q;
  reg [AW-1:0] raddr_q, wptr_q, seg_base_q;
  reg [2:0]    st_q;
  reg [7:0]    seg_q;
  reg          done_q, trig_seen_q;
  reg [WIDTH-1:0] probe_s1_q, probe_s2_q;
  reg             qual_s1_q, qual_s2_q;
  reg [MAX_SEGS-1:0] trig_s1_q, trig_s2_q;
  // ****************************************
  // Configuration decode
  // ****************************************
  wire          seg_mode = cfg_q[`TCB_CFG_SEG_EN];                          // see RULE2
  wire [1:0]    pos_sel  = cfg_q[`TCB_CFG_POS_HI:`TCB_CFG_POS_LO];
  wire [3:0]    nseg_log = seg_mode ? cfg_q[`TCB_CFG_NSEG_HI:`TCB_CFG_NSEG_LO] : 4'h0;
  wire [AW:0]   seg_depth = depth_q >> nseg_log;                            // see RULE16, RULE8
  wire [AW:0]   nseg      = {{AW{1'b0}}, 1'b1} << nseg_log;
  // Post-trigger sample count for the chosen position
  function [AW:0] post_count;
    input [1:0]  sel;
    input [AW:0] d;
    input [AW:0] cust;
    begin
      case (sel)
        `TCB_POS_POST:   post_count = d >> 3;                              // see RULE6
        `TCB_POS_CENTER: post_count = d >> 1;                              // see RULE6
        `TCB_POS_PRE:    post_count = d - (d >> 3);                        // see RULE6
        default:         post_count = (cust > d) ? d : cust;               // see RULE7
      endcase
    end
  endfunction
  // Wrap a pointer inside one segment
  function [AW-1:0] seg_wrap;
    input [AW-1:0] p;
    input [AW-1:0] base;
    input [AW:0]   sd;
    begin
      if ({1'b0, p - base} + 19'd1 >= {1'b0, sd})
        seg_wrap = base;                                                   // see RULE16, RULE4
      else
        seg_wrap = p + ONE;
    end
  endfunction
  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Probes come from another domain in general, so two flops first
  always @(posedge aclk) begin
    if (!aresetn) begin
      {probe_s1_q, qual_s1_q, trig_s1_q} <= {(WIDTH+1+MAX_SEGS){1'b0}};
      {probe_s2_q, qual_s2_q, trig_s2_q} <= {(WIDTH+1+MAX_SEGS){1'b0}};
    end else if (ce) begin
      {probe_s1_q, qual_s1_q, trig_s1_q} <= {probe, qual, trig};
      {probe_s2_q, qual_s2_q, trig_s2_q} <= {probe_s1_q, qual_s1_q, trig_s1_q};
    end
  end
  // ****************************************
  // Acquisition engine
  // ****************************************
  wire cust_flow = (pos_sel == `TCB_POS_CUSTOM);
  wire trig_hit  = (cust_flow && seg_q < MAX_SEGS) ? trig_s2_q[seg_q[3:0]] : trig_s2_q[0];  // see RULE12
  // Qualifier only counts in undivided mode
  wire wr_ok   = (ctrl_q[`TCB_CTRL_QUAL_EN] && !seg_mode) ? qual_s2_q : 1'b1; // see RULE13, RULE15
  wire capt    = (st_q != ST_IDLE) && wr_ok && (seg_depth != 0);
  wire arm_wr;
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= ST_IDLE;
      wptr_q      <= {AW{1'b0}};
      post_q      <= {(AW+1){1'b0}};
      seg_q       <= 8'h00;
      seg_base_q  <= {AW{1'b0}};
      done_q      <= 1'b0;
      trig_seen_q <= 1'b0;
    end else if (ce) begin
      case (st_q)
        ST_IDLE: begin
          if (arm_wr) begin
            st_q        <= ST_PRE;
            wptr_q      <= {AW{1'b0}};
            seg_base_q  <= {AW{1'b0}};
            seg_q       <= 8'h00;
            done_q      <= 1'b0;
            trig_seen_q <= 1'b0;
          end
        end
        ST_PRE: begin
          // Keep wrapping over the oldest samples until the trigger
          if (capt) begin
            wptr_q <= seg_wrap(wptr_q, seg_base_q, seg_depth);             // see RULE3, RULE4, RULE9
          end
          if (trig_hit) begin
            trig_seen_q <= 1'b1;
            post_q      <= post_count(pos_sel, seg_depth, tpos_q);
            st_q        <= ST_POST;
          end
        end
        ST_POST: begin
          // Fill the remainder; a short pre-trigger history just stays short
          if (post_q == 0) begin
            if ({9'h000, seg_q} + 18'd1 >= {9'h000, nseg[8:0]} || !seg_mode) begin
              st_q   <= ST_IDLE;                                           // see RULE5
              done_q <= 1'b1;
            end else begin
              seg_q      <= seg_q + 8'h01;                                 // see RULE11, RULE10
              seg_base_q <= seg_base_q + seg_depth[AW-1:0];
              wptr_q     <= seg_base_q + seg_depth[AW-1:0];
              st_q       <= ST_PRE;
            end
          end else if (capt) begin
            wptr_q <= seg_wrap(wptr_q, seg_base_q, seg_depth);             // see RULE5, RULE9
            post_q <= post_q - 1'b1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  // Dedicated capture store, not reachable by user logic
  wire [WIDTH-1:0] mem_rdata;
  tcb_mem #(.WIDTH(WIDTH), .AW(AW)) u_mem (                                // see RULE14
    .aclk  (aclk),
    .ce    (ce),
    .we    (capt && !(st_q == ST_POST && post_q == 0)),                    // see RULE10
    .waddr (wptr_q),
    .wdata (probe_s2_q),
    .re    (1'b1),
    .raddr (raddr_q),
    .rdata (mem_rdata)
  );
  // ****************************************
  // AXI4-Lite write side
  // ****************************************
  reg        aw_got_q, w_got_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  wire       wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
  assign arm_wr = wr_go && awaddr_q == `TCB_CTRL_OFS && wstrb_q[0] && wdata_q[`TCB_CTRL_ARM];
  // Byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  s;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (s[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction
  wire [31:0] depth_m = merge({{(31-AW){1'b0}}, depth_q}, wdata_q, wstrb_q);
  wire [31:0] tpos_m  = merge({{(31-AW){1'b0}}, tpos_q}, wdata_q, wstrb_q);
  wire [31:0] raddr_m = merge({{(32-AW){1'b0}}, raddr_q}, wdata_q, wstrb_q);
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TCB_RESP_OKAY;
      ctrl_q        <= `TCB_CTRL_RST;
      cfg_q         <= `TCB_CFG_RST;
      depth_q       <= MAX_DEPTH;
      tpos_q        <= {(AW+1){1'b0}};
      raddr_q       <= {AW{1'b0}};
    end else if (ce) begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `TCB_RESP_OKAY;
        case (awaddr_q)
          // Arm is a self-clearing pulse; config changes only while idle
          `TCB_CTRL_OFS:  ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'hffff_fffe;
          `TCB_CFG_OFS:   if (st_q == ST_IDLE) cfg_q <= merge(cfg_q, wdata_q, wstrb_q);
          `TCB_RADDR_OFS: raddr_q <= raddr_m[AW-1:0];
          `TCB_DEPTH_OFS: if (st_q == ST_IDLE) depth_q <= (depth_m > {14'h0000, MAX_DEPTH}) ?
                                                          MAX_DEPTH : depth_m[AW:0]; // see RULE1
          `TCB_TPOS_OFS:  if (st_q == ST_IDLE) tpos_q <= tpos_m[AW:0];       // see RULE7
          `TCB_STAT_OFS, `TCB_RDATA_OFS: ;
          default:        s_axi_bresp <= `TCB_RESP_SLVERR;
        endcase
      end
    end
  end
  // ****************************************
  // AXI4-Lite read side with two-entry buffer
  // ****************************************
  // Buffer holds one answer while rready stalls; arready rises only while the buffer is empty
  reg [33:0] rb0_q, rb1_q;
  reg [1:0]  rb_cnt_q;
  reg        rd_pend_q;
  reg [7:0]  araddr_q;
  wire       rb_pop  = s_axi_rvalid && s_axi_rready;
  wire [33:0] rd_word;
  // Register read mux; RDATA uses the memory's registered output
  assign rd_word =
    (araddr_q == `TCB_CTRL_OFS)  ? {`TCB_RESP_OKAY, ctrl_q} :
    (araddr_q == `TCB_CFG_OFS)   ? {`TCB_RESP_OKAY, cfg_q} :
    (araddr_q == `TCB_STAT_OFS)  ? {`TCB_RESP_OKAY, 16'h0000, seg_q, 5'h00, trig_seen_q, done_q,
                                    (st_q != ST_IDLE)} :
    (araddr_q == `TCB_RADDR_OFS) ? {`TCB_RESP_OKAY, {(32-AW){1'b0}}, raddr_q} :
    (araddr_q == `TCB_RDATA_OFS) ? {`TCB_RESP_OKAY, mem_rdata[31:0]} :
    (araddr_q == `TCB_TPOS_OFS)  ? {`TCB_RESP_OKAY, {(31-AW){1'b0}}, tpos_q} :
    (araddr_q == `TCB_DEPTH_OFS) ? {`TCB_RESP_OKAY, {(31-AW){1'b0}}, depth_q} :
                                   {`TCB_RESP_SLVERR, 32'h0000_0000};
  wire rb_push = rd_pend_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      rd_pend_q     <= 1'b0;
      araddr_q      <= 8'h00;
      rb0_q         <= 34'h0_0000_0000;
      rb1_q         <= 34'h0_0000_0000;
      rb_cnt_q      <= 2'd0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TCB_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !rd_pend_q && s_axi_arvalid && rb_cnt_q == 2'd0;
      rd_pend_q     <= s_axi_arready && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid)
        araddr_q <= s_axi_araddr;
      case ({rb_push, rb_pop})
        2'b10: begin
          if (rb_cnt_q == 2'd0) rb0_q <= rd_word;
          else                  rb1_q <= rd_word;
          rb_cnt_q <= rb_cnt_q + 2'd1;
        end
        2'b01: begin
          rb0_q    <= rb1_q;
          rb_cnt_q <= rb_cnt_q - 2'd1;
        end
        2'b11: begin
          if (rb_cnt_q == 2'd1) rb0_q <= rd_word;
          else begin
            rb0_q <= rb1_q;
            rb1_q <= rd_word;
          end
        end
        default: ;
      endcase
      s_axi_rvalid <= 1'b0;
      if (rb_cnt_q != 2'd0 && !(rb_pop && rb_cnt_q == 2'd1) || rb_push) begin
        s_axi_rvalid <= 1'b1;
      end
      if (!s_axi_rvalid || rb_pop) begin
        {s_axi_rresp, s_axi_rdata} <= (rb_cnt_q == 2'd0 || (rb_pop && rb_cnt_q == 2'd1)) ? rd_word :
                                      (rb_pop ? rb1_q : rb0_q);
      end
    end
  end
endmodule

// ==== core/tcb_regs.vh ====
// Register offsets, field positions, reset values and encodings of the trace capture buffer
`ifndef TCB_REGS_VH
`define TCB_REGS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define TCB_CTRL_OFS      8'h00
`define TCB_CFG_OFS       8'h04
`define TCB_STAT_OFS      8'h08
`define TCB_RADDR_OFS     8'h0c
`define TCB_RDATA_OFS     8'h10
`define TCB_TPOS_OFS      8'h14
`define TCB_DEPTH_OFS     8'h18
// ****************************************
// Field positions
// ****************************************
`define TCB_CTRL_ARM      0
`define TCB_CTRL_QUAL_EN  1
`define TCB_CFG_SEG_EN    0
`define TCB_CFG_POS_LO    4
`define TCB_CFG_POS_HI    5
`define TCB_CFG_NSEG_LO   8
`define TCB_CFG_NSEG_HI   11
`define TCB_STAT_BUSY     0
`define TCB_STAT_DONE     1
`define TCB_STAT_TRIG     2
`define TCB_STAT_SEG_LO   8
`define TCB_STAT_SEG_HI   15
// ****************************************
// Trigger position encodings
// ****************************************
`define TCB_POS_POST      2'b00
`define TCB_POS_CENTER    2'b01
`define TCB_POS_PRE       2'b10
`define TCB_POS_CUSTOM    2'b11
// ****************************************
// Reset values and bus responses
// ****************************************
`define TCB_CTRL_RST      32'h0000_0000
`define TCB_CFG_RST       32'h0000_0000
`define TCB_RESP_OKAY     2'b00
`define TCB_RESP_SLVERR   2'b10
`endif

// ==== core/tcb_mem.v ====
// Simple dual-port capture memory with registered read data
`timescale 1ns/1ps
module tcb_mem #(
  parameter WIDTH = 32,
  parameter AW    = 17
) (
  // Clock
  input  wire             aclk,
  input  wire             ce,
  // Write port
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  // Read port
  input  wire             re,
  input  wire [AW-1:0]    raddr,
  output reg  [WIDTH-1:0] rdata
);
  // Storage array, no reset so it maps onto block memory
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // Write on sample, registered read for the bus side
  always @(posedge aclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      if (re) begin
        rdata <= mem[raddr];
      end
    end
  end
endmodule

// ==== verification/tcb_top_assertions.sv ====
// Register bus checks for the trace capture buffer
`timescale 1ns/1ps
`include "tcb_regs.vh"
module tcb_chk (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  // Write side
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  // Read side
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held");
  a_w_taken: assert property (s_axi_wvalid && !s_axi_wready && !s_axi_bvalid |-> ##[0:4] s_axi_wready)
    else $error("write data not taken");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid)
    else $error("read answer late");
  a_read_unasked: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready, 2) || $past(s_axi_arready, 3))
    else $error("read answer without request");
  a_hole_slverr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `TCB_DEPTH_OFS
    |-> ##[2:3] s_axi_rvalid && s_axi_rresp == `TCB_RESP_SLVERR) else $error("unmapped read not refused");
  a_map_okay: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= `TCB_DEPTH_OFS
    && s_axi_araddr[1:0] == 2'b00 |-> ##[2:3] s_axi_rvalid && s_axi_rresp == `TCB_RESP_OKAY)
    else $error("mapped read refused");
endmodule

bind tcb_top tcb_chk tcb_chk_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp);

// ==== verification/tcb_probe_model.sv ====
// Probed user logic driving samples, qualifier and triggers
`timescale 1ns/1ps
module tcb_probe_model (
  // Clock
  input  logic        aclk,
  // Controls from the bench
  input  logic        trig_en,
  input  logic        qual_alt,
  // Probed signals
  output logic [31:0] probe,
  output logic        qual,
  output logic [15:0] trig
);
  logic [31:0] cnt_q = 32'h0000_0000;
  // Free counter as data so stored order and gaps are visible
  always @(posedge aclk) cnt_q <= cnt_q + 1;
  assign probe = cnt_q;
  // Alternating qualifier marks only even samples for storage
  assign qual = qual_alt ? ~cnt_q[0] : 1'b1;
  // Trigger on multiples of 32, so the newest sample's low five bits are the post count, or twice it when only even samples are stored
  assign trig = {16{trig_en && cnt_q[4:0] == 5'h00}};
endmodule

// ==== verification/tcb_top_tb.sv ====
// Self-checking bench for the trace capture buffer
`timescale 1ns/1ps
`include "tcb_regs.vh"
module tcb_top_tb;
  typedef struct {logic [31:0] m; logic [31:0] d; logic [1:0] r;} tcb_exp_t;
  localparam logic [1:0] OK = `TCB_RESP_OKAY;
  // ****************************************
  // Signals
  // ****************************************
  logic        aclk = 0, aresetn = 0, trig_en = 0, qual_alt = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, qual;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata, probe;
  wire  [15:0] trig;
  tcb_exp_t    rq[$];
  logic [1:0]  bq[$];
  int          errors = 0, checked = 0, cyc = 0;
  logic [31:0] d, mx, pm;
  int          tp;
  // 125 MHz clock
  always #4 aclk = ~aclk;
  tcb_top tcb_top_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .probe(probe), .qual(qual), .trig(trig),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
  tcb_probe_model tcb_probe_model_i (.aclk(aclk), .trig_en(trig_en), .qual_alt(qual_alt), .probe(probe),
    .qual(qual), .trig(trig));
  // ****************************************
  // Checking and closing
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Monitor takes the oldest note whenever a response is accepted
  always @(posedge aclk) begin
    tcb_exp_t e;
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      chk("rdata", s_axi_rdata & e.m, e.d & e.m);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, e.r});
    end
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
  end
  // Hang guard well above the expected run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      wrap_up;
    end
  end
  // ****************************************
  // Bus tasks: hold each channel until its ready, one spare edge at the end
  // ****************************************
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1'($urandom);
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r,
          output logic [31:0] v);
    rq.push_back('{m, e, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1'($urandom);
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1;
    end while (!(s_axi_rvalid && s_axi_rready));
    v = s_axi_rdata;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  // Arm, let the store wrap, then trigger and wait for done
  task capture(input logic qa);
    logic [31:0] v;
    qual_alt <= qa;
    wr(`TCB_CTRL_OFS, {30'h0, qa, 1'b1}, OK);
    wr(`TCB_DEPTH_OFS, 32'h0000_0008, OK);
    repeat (40 + $urandom % 20) @(posedge aclk);
    trig_en <= 1;
    v = 0;
    while (!v[1]) rd(`TCB_STAT_OFS, 0, 0, OK, v);
    trig_en <= 0;
    rd(`TCB_STAT_OFS, 32'h0000_0003, 32'h0000_0002, OK, v);
    rd(`TCB_DEPTH_OFS, '1, 32'h0000_0010, OK, v);
  endtask
  // Read a window back; it must be one run of samples ending the post count after a trigger
  task win(input int base, input int n, input int step, input int post, output logic [31:0] hi);
    logic [31:0] v, lo;
    lo = '1;
    hi = 0;
    for (int i = 0; i < n; i++) begin
      wr(`TCB_RADDR_OFS, base + i, OK);
      rd(`TCB_RDATA_OFS, 0, 0, OK, v);
      if (v < lo) lo = v;
      if (v > hi) hi = v;
      if (step == 2) chk("even", {31'h0, v[0]}, 32'h0000_0000);
    end
    chk("span", hi - lo, (n - 1) * step);
    if (post >= 0) chk("post", hi & 31, post);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(50595));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`TCB_CTRL_OFS, '1, `TCB_CTRL_RST, OK, d);
    rd(`TCB_CFG_OFS, '1, `TCB_CFG_RST, OK, d);
    rd(`TCB_DEPTH_OFS, '1, 32'h0002_0000, OK, d);
    rd(8'h1c, 0, 0, `TCB_RESP_SLVERR, d);
    wr(8'h1c, 32'h0000_0001, `TCB_RESP_SLVERR);
    wr(`TCB_DEPTH_OFS, 32'h0000_0010, OK);
    rd(`TCB_DEPTH_OFS, '1, 32'h0000_0010, OK, d);
    // Each trigger position on the undivided store
    for (int p = 0; p < 4; p++) begin
      tp = 1 + $urandom % 12;
      wr(`TCB_TPOS_OFS, tp, OK);
      wr(`TCB_CFG_OFS, p << 4, OK);
      capture(0);
      win(0, 16, 1, p == 0 ? 2 : p == 1 ? 8 : p == 2 ? 14 : tp, mx);
    end
    // Qualified capture keeps only the marked samples
    wr(`TCB_CFG_OFS, 32'h0000_0000, OK);
    capture(1);
    win(0, 16, 2, 4, mx);
    // Four segments, centre position, qualifier ignored
    wr(`TCB_CFG_OFS, 32'h0000_0211, OK);
    capture(1);
    pm = 0;
    for (int k = 0; k < 4; k++) begin
      win(4 * k, 4, 1, 2, mx);
      if (k > 0) chk("order", {31'h0, mx > pm}, 32'h0000_0001);
      pm = mx;
    end
    wrap_up;
  end
endmodule
